// File: rtl/ecs_gain_map.sv
// Purpose: turns the receive gain code into a signed gain in dB
// Assumes: code held stable by the register bank
// Notes: one cycle from code to gain
`default_nettype none
module ecs_gain_map import ecs_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [3:0] code,
  output logic signed [7:0] gain_db
);

  ecs_gain_state_t s_q;
  ecs_gain_state_t s_d;

  always_comb begin
    s_d = s_q;
    s_d.gain_db = ECS_GAIN_DB[code];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q.gain_db <= ECS_GAIN_DB[ecs_gain_code(ECS_RST_RX_GAIN)];
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign gain_db = s_q.gain_db;

endmodule // ecs_gain_map
`default_nettype wire

// File: rtl/ecs_pkg.sv
// Purpose: shared constants and types of the echo canceller status and gain registers
// Assumes: 8-bit register data, 8-bit register addresses
// Notes: offsets are the register addresses of the microport
`default_nettype none
package ecs_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] ECS_OFS_LINE_STATUS = 8'h02;
  localparam logic [7:0] ECS_OFS_RX_GAIN = 8'h20;
  localparam logic [7:0] ECS_OFS_ACOUSTIC_STATUS = 8'h22;

  localparam logic [7:0] ECS_RST_LINE_STATUS = 8'h00;
  localparam logic [7:0] ECS_RST_RX_GAIN = 8'h6d;
  localparam logic [7:0] ECS_RST_ACOUSTIC_STATUS = 8'h00;
  localparam logic [7:0] ECS_RDATA_UNMAPPED = 8'h00;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int ECS_BIT_NB_PATH = 0;
  localparam int ECS_BIT_NB_ANY = 1;
  localparam int ECS_BIT_DOUBLE_TALK = 2;
  localparam int ECS_BIT_NONLINEAR = 3;
  localparam int ECS_BIT_HOWLING = 5;
  localparam int ECS_BIT_RX_IDLE = 6;
  localparam int ECS_GAIN_MSB = 3;
  localparam int ECS_GAIN_LSB = 0;

  // ----------------------------------------
  // gain encoding, dB per code 0h..Fh
  // ----------------------------------------
  localparam logic signed [7:0] ECS_GAIN_DB [16] = '{
    8'sh0c, 8'sh0f, 8'sh12, 8'sh15,
    -8'sh18, -8'sh15, -8'sh12, -8'sh0f,
    -8'sh0c, -8'sh09, -8'sh06, -8'sh03,
    8'sh00, 8'sh03, 8'sh06, 8'sh09
  };

  // ----------------------------------------
  // carriers
  // ----------------------------------------
  typedef struct packed {
    logic narrowband_send_flag;
    logic narrowband_receive_flag;
    logic acoustic_double_talk_flag;
    logic line_double_talk_flag;
    logic acoustic_nonlinear_active;
    logic line_nonlinear_active;
    logic howling_flag;
    logic receive_idle_flag;
  } ecs_detect_t;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } ecs_req_t;

  typedef struct packed {
    logic [7:0] receive_gain_register;
    logic [7:0] rdata;
    logic rvalid;
  } ecs_regs_state_t;

  typedef struct packed {
    logic signed [7:0] gain_db;
  } ecs_gain_state_t;

  function automatic logic [3:0] ecs_gain_code(input logic [7:0] reg_value);
    return reg_value[ECS_GAIN_MSB:ECS_GAIN_LSB];
  endfunction

endpackage
`default_nettype wire

// File: rtl/ecs_regs.sv
// Purpose: status and receive gain registers of the dual echo canceller
// Assumes: microport decoded to one-cycle read and write strobes, all on clk
// Notes: status reads are live, one read latency cycle
//   writes to the status offsets are dropped silently
//   clock enable low freezes every register, read data included
//
// Functional notes
// - acoustic bit0 shows send-path narrowband detect
// - bit1 of both is send OR receive narrowband
// - acoustic bit2 shows acoustic double-talk
// - acoustic bit3 shows acoustic nonlinear processor active
// - acoustic bit5 shows howling in loop
// - acoustic bit6 shows receive path idle
// - line bit0 shows receive-path narrowband detect
// - line bit2 shows line double-talk
// - line bit3 shows line nonlinear processor active
// - gain register holds writable 4-bit code
// - gain code bits 3..0, upper bits reserved
// - codes map in 3 dB steps
`default_nettype none
module ecs_regs import ecs_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire ecs_req_t req,
  input wire ecs_detect_t det,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [7:0] receive_gain_register,
  output logic signed [7:0] rx_gain_db
);

  ecs_regs_state_t s_q;
  ecs_regs_state_t s_d;
  wire logic [7:0] acoustic_status_register;
  wire logic [7:0] line_status_register;
  logic [7:0] read_word;
  logic gain_write;

  // ----------------------------------------
  // reset image of the held state
  // ----------------------------------------
  localparam ecs_regs_state_t REGS_RESET = '{
    receive_gain_register: ECS_RST_RX_GAIN,
    rdata: ECS_RDATA_UNMAPPED,
    rvalid: 1'b0
  };

  // ----------------------------------------
  // register map decode
  // ----------------------------------------
  // which register an address selects; unmapped addresses read zero
  typedef enum {
    ECS_SEL_NONE,
    ECS_SEL_LINE,
    ECS_SEL_GAIN,
    ECS_SEL_ACOUSTIC
  } ecs_sel_t;

  // shared by the write enable and the read mux so the two cannot disagree
  function automatic ecs_sel_t decode_sel(input logic [7:0] addr);
    ecs_sel_t sel;
    sel = ECS_SEL_NONE;
    unique case (addr)
      ECS_OFS_LINE_STATUS: begin
        sel = ECS_SEL_LINE;
      end
      ECS_OFS_RX_GAIN: begin
        sel = ECS_SEL_GAIN;
      end
      ECS_OFS_ACOUSTIC_STATUS: begin
        sel = ECS_SEL_ACOUSTIC;
      end
      default: begin
        sel = ECS_SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  // ----------------------------------------
  // status bit sources
  // ----------------------------------------
  // narrowband summary, the same in both status words
  function automatic logic nb_any(input ecs_detect_t d);
    return d.narrowband_send_flag | d.narrowband_receive_flag;
  endfunction

  // one acoustic status bit by position; reserved positions keep the reset value
  function automatic logic acoustic_bit(input int pos, input ecs_detect_t d);
    logic b;
    b = 1'b0;
    unique case (pos)
      ECS_BIT_NB_PATH: begin
        b = d.narrowband_send_flag;
      end
      ECS_BIT_NB_ANY: begin
        b = nb_any(d);
      end
      ECS_BIT_DOUBLE_TALK: begin
        b = d.acoustic_double_talk_flag;
      end
      ECS_BIT_NONLINEAR: begin
        b = d.acoustic_nonlinear_active;
      end
      ECS_BIT_HOWLING: begin
        b = d.howling_flag;
      end
      ECS_BIT_RX_IDLE: begin
        b = d.receive_idle_flag;
      end
      default: begin
        b = ECS_RST_ACOUSTIC_STATUS[pos];
      end
    endcase
    return b;
  endfunction

  // one line status bit by position; reserved positions keep the reset value
  function automatic logic line_bit(input int pos, input ecs_detect_t d);
    logic b;
    b = 1'b0;
    unique case (pos)
      ECS_BIT_NB_PATH: begin
        b = d.narrowband_receive_flag;
      end
      ECS_BIT_NB_ANY: begin
        b = nb_any(d);
      end
      ECS_BIT_DOUBLE_TALK: begin
        b = d.line_double_talk_flag;
      end
      ECS_BIT_NONLINEAR: begin
        b = d.line_nonlinear_active;
      end
      default: begin
        b = ECS_RST_LINE_STATUS[pos];
      end
    endcase
    return b;
  endfunction

  // ----------------------------------------
  // live status words
  // ----------------------------------------
  // each mapped bit follows its detector level, reserved bits stay at the reset value, nothing is latched
  for (genvar i = 0; i < $bits(acoustic_status_register); i++) begin : g_status
    assign acoustic_status_register[i] = acoustic_bit(i, det);
    assign line_status_register[i] = line_bit(i, det);
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  // status offsets have no write enable, so a stray write leaves no trace
  assign gain_write = req.wr && (decode_sel(req.addr) == ECS_SEL_GAIN);

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  always_comb begin
    read_word = ECS_RDATA_UNMAPPED;
    unique case (decode_sel(req.addr))
      ECS_SEL_LINE: begin
        read_word = line_status_register;
      end
      ECS_SEL_GAIN: begin
        // held value: a write in the same cycle shows on the next read
        read_word = s_q.receive_gain_register;
      end
      ECS_SEL_ACOUSTIC: begin
        read_word = acoustic_status_register;
      end
      ECS_SEL_NONE: begin
        read_word = ECS_RDATA_UNMAPPED;
      end
    endcase
  end

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rvalid = req.rd;
    if (gain_write) begin
      s_d.receive_gain_register = req.wdata;
    end
    if (req.rd) begin
      s_d.rdata = read_word;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= REGS_RESET;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // gain decode
  // ----------------------------------------
  ecs_gain_map u_gain (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .code(ecs_gain_code(s_q.receive_gain_register)),
    .gain_db(rx_gain_db)
  );

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign rdata = s_q.rdata;
  assign rvalid = s_q.rvalid;
  assign receive_gain_register = s_q.receive_gain_register;

endmodule // ecs_regs
`default_nettype wire

// File: test/ecs_host.sv
// Purpose: host model driving the register port
// Assumes: one transfer at a time
// Notes: released address and data lines show the inverse of the last value, strobes go low
`default_nettype none
module ecs_host import ecs_pkg::*; (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output var ecs_req_t req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial req = '0;
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk);
    #1;
    req = '{a, w && a != 8'h02 && a != 8'h22, !w, d};
    @(posedge clk);
    #1;
    q = rdata;
    req = '{~a, 1'b0, 1'b0, ~d};
  endtask
endmodule // ecs_host
`default_nettype wire

// File: test/ecs_regs_asserts.sv
// Purpose: port checks of the status and gain registers
// Assumes: single clock domain
// Notes: bound to ecs_regs
`default_nettype none
module ecs_regs_chk import ecs_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  input wire ecs_req_t req,
  input wire ecs_detect_t det,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [7:0] receive_gain_register,
  input wire logic signed [7:0] rx_gain_db
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire logic [3:0] c = receive_gain_register[3:0];
  wire logic signed [7:0] exp_db = c < 4 ? 8'(12 + 3 * c) : 8'(3 * c - 36);
  wire logic nb = det.narrowband_send_flag | det.narrowband_receive_flag;
  wire logic [7:0] acs = {1'b0, det.receive_idle_flag, det.howling_flag, 1'b0,
    det.acoustic_nonlinear_active, det.acoustic_double_talk_flag, nb, det.narrowband_send_flag};
  wire logic [7:0] lns = {4'h0, det.line_nonlinear_active, det.line_double_talk_flag, nb,
    det.narrowband_receive_flag};
  wire logic gw = ce && req.wr && req.addr == 8'h20;
  sequence rd_at(a);
    ce && req.rd && req.addr == a;
  endsequence
  a_rd_pulse: assert property (ce |=> rvalid == $past(req.rd)) else $error("rvalid wrong");
  a_ce_freeze: assert property (!ce |=> $stable(rdata) && $stable(rvalid) && $stable(rx_gain_db))
    else $error("state moved while clock enable low");
  a_acou_read: assert property (rd_at(8'h22) |=> rdata == $past(acs))
    else $error("acoustic status wrong");
  a_line_read: assert property (rd_at(8'h02) |=> rdata == $past(lns))
    else $error("line status wrong");
  a_gain_read: assert property (rd_at(8'h20) |=> rdata == $past(receive_gain_register))
    else $error("gain readback wrong");
  a_unmap_read: assert property (ce && req.rd && !(req.addr inside {8'h02, 8'h20, 8'h22})
    |=> rdata == 8'h00) else $error("unmapped read not zero");
  a_gain_write: assert property (gw |=> receive_gain_register == $past(req.wdata))
    else $error("gain write lost");
  a_gain_hold: assert property (!gw |=> $stable(receive_gain_register))
    else $error("gain changed");
  a_gain_map: assert property (ce |=> rx_gain_db == $past(exp_db))
    else $error("gain map wrong");
endmodule // ecs_regs_chk
bind ecs_regs ecs_regs_chk ecs_regs_chk_inst (.*);
`default_nettype wire

// File: test/ecs_regs_tb.sv
// Purpose: self-checking bench of the status and gain registers
// Assumes: ce dropped once mid-run to check the freeze
// Notes: detector patterns from a fixed xorshift seed
`default_nettype none
module ecs_regs_tb import ecs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, sys_rst = 1, ce = 1, rvalid;
  ecs_req_t req;
  ecs_detect_t det = '0;
  logic [7:0] rdata, receive_gain_register, q;
  logic signed [7:0] rx_gain_db;
  logic [31:0] s = 32'hf2eaf2c1;
  int error_cnt = 0, n_tests = 0, cyc = 0, g = 'h6d, exp_q[$];
  always #50 clk = ~clk;
  ecs_regs ecs_regs_inst (
    .clk(clk),
    .sys_rst(sys_rst),
    .ce(ce),
    .req(req),
    .det(det),
    .rdata(rdata),
    .rvalid(rvalid),
    .receive_gain_register(receive_gain_register),
    .rx_gain_db(rx_gain_db)
  );
  ecs_host ecs_host_inst (.clk(clk), .rdata(rdata), .req(req));
  function automatic logic [7:0] xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s[7:0];
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a);
    ecs_host_inst.xfer(a, 1'b0, 8'h00, q);
    chk(q, 8'(exp_q.pop_front()));
    chk({7'h00, rvalid}, 8'h01);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    logic [7:0] v;
    repeat (2) @(posedge clk);
    #1;
    sys_rst = 0;
    exp_q.push_back(g);
    rd(8'h20);
    chk(rx_gain_db, 8'h03);
    for (int i = 0; i < 16; i++) begin
      v = xs();
      g = {v[7:4], 4'(i)};
      ecs_host_inst.xfer(8'h20, 1'b1, 8'(g), q);
      chk(receive_gain_register, 8'(g));
      chk({7'h00, rvalid}, 8'h00);
      @(posedge clk);
      #1;
      chk(rx_gain_db, 8'(i < 4 ? 12 + 3 * i : 3 * i - 36));
      exp_q.push_back(g);
      rd(8'h20);
    end
    for (int i = 0; i < 24; i++) begin
      v = xs();
      det = v;
      exp_q.push_back({1'b0, v[0], v[1], 1'b0, v[3], v[5], v[7] | v[6], v[7]});
      rd(8'h22);
      exp_q.push_back({4'h0, v[2], v[4], v[7] | v[6], v[6]});
      rd(8'h02);
      v = xs();
      if (!(v inside {8'h02, 8'h20, 8'h22})) begin
        ecs_host_inst.xfer(v, 1'b1, ~v, q);
        exp_q.push_back(0);
        rd(v);
      end
    end
    exp_q.push_back(g);
    rd(8'h20);
    ce = 0;
    ecs_host_inst.xfer(8'h20, 1'b1, ~8'(g), q);
    ce = 1;
    chk(receive_gain_register, 8'(g));
    chk(rx_gain_db, 8'h09);
    exp_q.push_back(g);
    rd(8'h20);
    sys_rst = 1;
    @(posedge clk);
    #1;
    sys_rst = 0;
    g = 8'h6d;
    chk(receive_gain_register, 8'(g));
    chk(rx_gain_db, 8'h03);
    chk(rdata, 8'h00);
    chk({7'h00, rvalid}, 8'h00);
    exp_q.push_back(g);
    rd(8'h20);
    print_verdict();
  end
endmodule // ecs_regs_tb
`default_nettype wire
